/* ptimer_pkg.sv */
package ptimer_pkg;
  // Byte addresses of the register words
  localparam logic [7:0] CTRL0_OFS = 8'h00;
  localparam logic [7:0] CTRL1_OFS = 8'h04;
  localparam logic [7:0] CNT_LO_OFS = 8'h08;
  localparam logic [7:0] CNT_HI_OFS = 8'h0C;
  localparam logic [7:0] CMPA_LO_OFS = 8'h10;
  localparam logic [7:0] CMPA_HI_OFS = 8'h14;
  localparam logic [7:0] PER_LO_OFS = 8'h18;
  localparam logic [7:0] PER_HI_OFS = 8'h1C;
  localparam logic [7:0] FLAG_OFS = 8'h20;
  // Control zero fields
  localparam int PAUSE_BIT = 7;
  localparam int ON_BIT = 3;
  // Control one fields
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int PINF_HI = 5;
  localparam int PINF_LO = 4;
  localparam int INIT_BIT = 3;
  localparam int INV_BIT = 2;
  localparam int CAPTS_BIT = 1;
  localparam int CCLR_BIT = 0;
  // Flag register fields, write one to clear
  localparam int FLAG_A_BIT = 0;
  localparam int FLAG_P_BIT = 1;
  // Reset value and default counter width
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam int DEF_WIDTH = 10;
  // Mode codes
  localparam logic [1:0] MODE_CMP = 2'b00;
  localparam logic [1:0] MODE_CAP = 2'b01;
  localparam logic [1:0] MODE_PWM = 2'b10;
  localparam logic [1:0] MODE_TC = 2'b11;
  // Pin function codes
  localparam logic [1:0] PINF_NONE = 2'b00;
  localparam logic [1:0] PINF_LOW = 2'b01;
  localparam logic [1:0] PINF_HIGH = 2'b10;
  localparam logic [1:0] PINF_TOG = 2'b11;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* periodic_timer.sv */
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module periodic_timer #(
  parameter int W = ptimer_pkg::DEF_WIDTH
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic tick,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic pin_out,
  output logic pin_oe,
  output logic compare_a_flag,
  output logic period_match_flag
);
  import ptimer_pkg::*;
  default clocking chk_cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  logic [7:0] ctrl0_r, ctrl1_r;
  logic [W-1:0] cnt_r, cmpa_r, per_r;
  logic on_prev_r, pin_lvl_r;
  logic flag_a_r, flag_p_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic wstrb0_r;
  logic aw_got_r, w_got_r, bvalid_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;

  // Decoded controls
  logic counter_on, counter_pause, clear_source_select;
  logic output_initial_level, output_invert;
  logic [1:0] mode, pin_function;
  assign counter_on = ctrl0_r[ON_BIT];
  assign counter_pause = ctrl0_r[PAUSE_BIT];
  assign mode = ctrl1_r[MODE_HI:MODE_LO];
  assign pin_function = ctrl1_r[PINF_HI:PINF_LO];
  assign output_initial_level = ctrl1_r[INIT_BIT];
  assign output_invert = ctrl1_r[INV_BIT];
  assign clear_source_select = ctrl1_r[CCLR_BIT];

  // Counter events
  logic on_rise, run, cmp_like, is_pwm, at_max;
  logic match_a, match_p, clr, set_a, set_p;
  assign on_rise = counter_on & ~on_prev_r;
  assign run = counter_on & ~counter_pause & tick & ~on_rise;
  assign cmp_like = (mode == MODE_CMP) | (mode == MODE_TC);
  assign is_pwm = (mode == MODE_PWM);
  assign at_max = (cnt_r == {W{1'b1}});
  assign match_a = run & (cnt_r == cmpa_r);
  // Period zero means the period match falls on the overflow
  assign match_p = run & ((per_r == '0) ? at_max : (cnt_r == per_r));

  // Clear source per mode; wrap to zero at maximum is the overflow
  always_comb begin
    clr = 1'b0;
    set_a = 1'b0;
    set_p = 1'b0;
    if (cmp_like) begin
      if (clear_source_select) begin
        clr = match_a & (cmpa_r != '0);
      end else begin
        clr = match_p;
        set_p = match_p;
      end
      set_a = match_a & (cmpa_r != '0);
    end else if (is_pwm) begin
      clr = match_p;
      set_a = match_a;
      set_p = match_p;
    end else begin
      clr = match_p;
    end
  end

  // Running counter
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
      on_prev_r <= 1'b0;
    end else begin
      on_prev_r <= counter_on;
      if (on_rise) begin
        cnt_r <= '0;
      end else if (run) begin
        cnt_r <= clr ? '0 : cnt_r + 1'b1;
      end
    end
  end

  // Compare output level; period match never touches it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_lvl_r <= 1'b0;
    end else if (on_rise) begin
      pin_lvl_r <= output_initial_level;
    end else if (set_a && mode == MODE_CMP) begin
      case (pin_function)
        PINF_LOW: pin_lvl_r <= 1'b0;
        PINF_HIGH: pin_lvl_r <= 1'b1;
        PINF_TOG: pin_lvl_r <= ~pin_lvl_r;
        default: pin_lvl_r <= pin_lvl_r;
      endcase
    end
  end

  // Waveform; compare A above period gives full duty
  logic pwm_act, pin_nxt, drive;
  assign pwm_act = (cnt_r < cmpa_r);
  assign drive = (mode == MODE_CMP) | is_pwm;
  always_comb begin
    pin_nxt = pin_lvl_r;
    if (is_pwm) begin
      case (pin_function)
        PINF_NONE: pin_nxt = ~output_initial_level;
        PINF_LOW: pin_nxt = output_initial_level;
        PINF_HIGH: pin_nxt = pwm_act ? output_initial_level : ~output_initial_level;
        default: pin_nxt = ~output_initial_level;
      endcase
    end
  end

  // Pin registers; idle in capture and timer/counter modes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      pin_oe <= drive;
      pin_out <= drive ? pin_nxt ^ output_invert : 1'b0;
    end
  end

  // Bus write strobe
  logic wr_fire;
  logic [7:0] wbyte;
  assign wr_fire = aw_got_r & w_got_r & ~bvalid_r;
  assign wbyte = wdata_r[7:0];

  // Flags: a set in the clearing cycle wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flag_a_r <= 1'b0;
      flag_p_r <= 1'b0;
    end else begin
      if (set_a) begin
        flag_a_r <= 1'b1;
      end else if (wr_fire && wstrb0_r && awaddr_r == FLAG_OFS && wbyte[FLAG_A_BIT]) begin
        flag_a_r <= 1'b0;
      end
      if (set_p) begin
        flag_p_r <= 1'b1;
      end else if (wr_fire && wstrb0_r && awaddr_r == FLAG_OFS && wbyte[FLAG_P_BIT]) begin
        flag_p_r <= 1'b0;
      end
    end
  end
  assign compare_a_flag = flag_a_r;
  assign period_match_flag = flag_p_r;

  // Software registers; only byte lane 0 carries data
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl0_r <= CTRL_RST;
      ctrl1_r <= CTRL_RST;
      cmpa_r <= '0;
      per_r <= '0;
    end else if (wr_fire && wstrb0_r) begin
      if (awaddr_r == CTRL0_OFS) begin
        ctrl0_r <= {wbyte[PAUSE_BIT], 3'b000, wbyte[ON_BIT], 3'b000};
      end else if (awaddr_r == CTRL1_OFS) begin
        ctrl1_r <= wbyte;
      end else if (awaddr_r == CMPA_LO_OFS) begin
        cmpa_r[7:0] <= wbyte;
      end else if (awaddr_r == CMPA_HI_OFS) begin
        cmpa_r[W-1:8] <= wdata_r[W-9:0];
      end else if (awaddr_r == PER_LO_OFS) begin
        per_r[7:0] <= wbyte;
      end else if (awaddr_r == PER_HI_OFS) begin
        per_r[W-1:8] <= wdata_r[W-9:0];
      end
    end
  end

  // Address map check shared by both channels
  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= FLAG_OFS);
  endfunction

  // Write channels taken in either order
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb0_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb0_r <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end
  assign s_axi_awready = ~aw_got_r & ~bvalid_r;
  assign s_axi_wready = ~w_got_r & ~bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // Zero-extended views; narrow builds read zero above bit W-1
  logic [15:0] cnt16, cmpa16, per16;
  assign cnt16 = 16'(cnt_r);
  assign cmpa16 = 16'(cmpa_r);
  assign per16 = 16'(per_r);

  // Read channel, one cycle to answer
  logic [7:0] rbyte;
  always_comb begin
    rbyte = 8'h00;
    if (s_axi_araddr == CTRL0_OFS) begin
      rbyte = ctrl0_r;
    end else if (s_axi_araddr == CTRL1_OFS) begin
      rbyte = ctrl1_r;
    end else if (s_axi_araddr == CNT_LO_OFS) begin
      rbyte = cnt16[7:0];
    end else if (s_axi_araddr == CNT_HI_OFS) begin
      rbyte = cnt16[15:8];
    end else if (s_axi_araddr == CMPA_LO_OFS) begin
      rbyte = cmpa16[7:0];
    end else if (s_axi_araddr == CMPA_HI_OFS) begin
      rbyte = cmpa16[15:8];
    end else if (s_axi_araddr == PER_LO_OFS) begin
      rbyte = per16[7:0];
    end else if (s_axi_araddr == PER_HI_OFS) begin
      rbyte = per16[15:8];
    end else if (s_axi_araddr == FLAG_OFS) begin
      rbyte = {6'b00_0000, flag_p_r, flag_a_r};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rdata_r <= {24'h00_0000, rbyte};
      rresp_r <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // Checks; clock and reset come from the defaults at the top
  property p_on_rise_zero;
    on_rise |=> (cnt_r == '0);
  endproperty
  a_on_rise_zero: assert property (p_on_rise_zero)
    else $error("counter not zero after enable");
  property p_off_hold;
    (!counter_on ##1 !counter_on) |-> $stable(cnt_r);
  endproperty
  a_off_hold: assert property (p_off_hold)
    else $error("counter moved while off");
  property p_pause_hold;
    (counter_on && counter_pause && !on_rise) |=> $stable(cnt_r);
  endproperty
  a_pause_hold: assert property (p_pause_hold)
    else $error("counter moved while paused");
  property p_step;
    (run && !clr) |=> (cnt_r == $past(cnt_r) + 1'b1);
  endproperty
  a_step: assert property (p_step)
    else $error("counter did not step by one");
  property p_no_pflag;
    (cmp_like && clear_source_select && !flag_p_r) |=> !flag_p_r;
  endproperty
  a_no_pflag: assert property (p_no_pflag)
    else $error("period flag set with select high");
  property p_zero_a;
    (cmp_like && cmpa_r == '0 && !flag_a_r) |=> !flag_a_r;
  endproperty
  a_zero_a: assert property (p_zero_a)
    else $error("compare A flag with zero value");
  property p_init_level;
    (on_rise && mode == MODE_CMP) |=> (pin_lvl_r == $past(output_initial_level));
  endproperty
  a_init_level: assert property (p_init_level)
    else $error("pin not loaded with initial level");
  property p_tc_quiet;
    (mode == MODE_TC) [*2] |-> (!pin_oe && !pin_out);
  endproperty
  a_tc_quiet: assert property (p_tc_quiet)
    else $error("pin driven in timer/counter mode");
  property p_pwm_flags;
    (is_pwm && match_a) |=> flag_a_r;
  endproperty
  a_pwm_flags: assert property (p_pwm_flags)
    else $error("compare A flag missing in PWM");
  property p_high_set;
    (set_a && mode == MODE_CMP && pin_function == PINF_HIGH && !on_rise) |=> pin_lvl_r;
  endproperty
  a_high_set: assert property (p_high_set)
    else $error("pin not high after match");
  c_pwm_wrap: cover property (is_pwm && match_p);
  c_toggle: cover property (set_a && pin_function == PINF_TOG);
  c_overflow: cover property (run && at_max);
  c_write: cover property (wr_fire);
endmodule // periodic_timer

/* pin_load.sv */
`timescale 1ns/1ps
// Load on the timer pin; pulled down while the pin is not driven
module pin_load (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic level,
  output logic [15:0] high_len,
  output logic [15:0] low_len
);
  logic [15:0] run_r;
  logic last_r;

  // Undriven pin never shows a stale level
  assign level = pin_oe ? pin_out : 1'b0;

  // Length of the last high and low run, latched at each change
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      run_r <= 16'h0001;
      last_r <= 1'b0;
      high_len <= 16'h0000;
      low_len <= 16'h0000;
    end else if (level != last_r) begin
      if (last_r) high_len <= run_r;
      else low_len <= run_r;
      run_r <= 16'h0001;
      last_r <= level;
    end else begin
      run_r <= run_r + 16'h0001;
    end
  end
endmodule // pin_load

/* periodic_timer_tb.sv */
`timescale 1ns/1ps
module periodic_timer_tb;
  import ptimer_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic tick = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pin_out, pin_oe, fa, fp, level;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd, rd2;
  logic [15:0] high_len, low_len;
  logic [7:0] ofs [9] = '{CTRL0_OFS, CTRL1_OFS, CNT_LO_OFS, CNT_HI_OFS, CMPA_LO_OFS,
    CMPA_HI_OFS, PER_LO_OFS, PER_HI_OFS, FLAG_OFS};
  logic [3:0] ini = 4'b1011;
  logic [3:0] exp_pin = 4'b0101;
  int n_fail = 0;
  int total_checks = 0;

  periodic_timer #(.W(10)) i_dut (.clk(clk), .arst_n(arst_n), .tick(tick),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_out(pin_out), .pin_oe(pin_oe),
    .compare_a_flag(fa), .period_match_flag(fp));

  pin_load i_load (.clk(clk), .arst_n(arst_n), .pin_out(pin_out), .pin_oe(pin_oe),
    .level(level), .high_len(high_len), .low_len(low_len));

  // Free-running 100 MHz clock
  always #5 clk = ~clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic done;
    done = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        bready <= 1'b0;
        resp = bresp;
        done = 1'b1;
      end
    end
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] d);
    logic done;
    done = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        rready <= 1'b0;
        resp = rresp;
        d = rdata;
        done = 1'b1;
      end
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    rdr(a, rd);
    chk(rd, {24'h00_0000, e});
    chk(32'(resp), 32'(RESP_OKAY));
  endtask

  // Polls a flag port; gives up after 3000 cycles if the flag never comes
  task automatic wait_flag(input logic sel);
    for (int i = 0; i < 3000; i++) begin
      if ((sel ? fp : fa) === 1'b1) break;
      @(posedge clk);
    end
  endtask

  function automatic logic [7:0] c1(input logic [1:0] m, input logic [1:0] p,
      input logic ini_b, input logic inv, input logic clr);
    return {m, p, ini_b, inv, 1'b0, clr};
  endfunction

  // Mode changes only while stopped, as software must
  task automatic start(input logic [7:0] c);
    wr(CTRL0_OFS, 8'h00);
    wr(CTRL1_OFS, c);
    wr(FLAG_OFS, 8'h03);
    rd_chk(CTRL1_OFS, c);
    rd_chk(FLAG_OFS, 8'h00);
    wr(CTRL0_OFS, 8'h08);
    repeat (3) @(posedge clk);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial begin
    repeat (50000) @(posedge clk);
    n_fail++;
    close_out();
  end

  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    tick <= 1'b1;
    for (int i = 0; i < 9; i++) rd_chk(ofs[i], 8'h00);
    wr(CNT_LO_OFS, 8'h5a);
    rd_chk(CNT_LO_OFS, 8'h00);
    wr(8'h24, 8'h01);
    chk(32'(resp), 32'(RESP_SLVERR));
    wr(CMPA_HI_OFS, 8'hff);
    wr(PER_HI_OFS, 8'hff);
    rd_chk(CMPA_HI_OFS, 8'h03);
    rd_chk(PER_HI_OFS, 8'h03);
    wr(CMPA_HI_OFS, 8'h00);
    wr(PER_HI_OFS, 8'h00);
    $display("test registers done");
    // Every pin function in compare mode, initial level chosen to show a change for all but PINF_NONE
    wr(PER_LO_OFS, 8'hc8);
    wr(CMPA_LO_OFS, 8'h0a);
    for (int i = 0; i < 4; i++) begin
      start(c1(MODE_CMP, 2'(i), ini[i], 1'b0, 1'b0));
      chk(32'(level), 32'(ini[i]));
      wait_flag(1'b0);
      repeat (3) @(posedge clk);
      chk(32'(level), 32'(exp_pin[i]));
      wait_flag(1'b1);
      repeat (3) @(posedge clk);
      chk(32'(level), 32'(exp_pin[i]));
      chk(32'({fa, fp}), 32'h3);
      rdr(CNT_LO_OFS, rd);
      chk(32'(rd < 16), 32'h1);
    end
    $display("test compare done");
    // Clear on compare A with period below it; pin left alone
    wr(PER_LO_OFS, 8'h05);
    wr(CMPA_LO_OFS, 8'h1e);
    start(c1(MODE_TC, PINF_TOG, 1'b1, 1'b1, 1'b1));
    repeat (200) @(posedge clk);
    chk(32'({fa, fp}), 32'h2);
    chk(32'({pin_oe, pin_out}), 32'h0);
    rdr(CNT_LO_OFS, rd);
    chk(32'(rd <= 30), 32'h1);
    $display("test clear select done");
    // Capture mode is not built: counts and wraps on period, no flags, pin released
    start(c1(MODE_CAP, PINF_NONE, 1'b0, 1'b0, 1'b0));
    repeat (50) @(posedge clk);
    chk(32'({fa, fp, pin_oe}), 32'h0);
    rdr(CNT_LO_OFS, rd);
    chk(32'(rd <= 5), 32'h1);
    $display("test capture done");
    // Zero compare A and period: run to the top and overflow
    wr(PER_LO_OFS, 8'h00);
    wr(CMPA_LO_OFS, 8'h00);
    start(c1(MODE_CMP, PINF_NONE, 1'b0, 1'b0, 1'b0));
    repeat (1000) @(posedge clk);
    rd_chk(CNT_HI_OFS, 8'h03);
    repeat (100) @(posedge clk);
    chk(32'({fa, fp}), 32'h1);
    $display("test overflow done");
    // Pause, missing ticks and switch-off all hold the count
    start(c1(MODE_CMP, PINF_NONE, 1'b0, 1'b0, 1'b0));
    repeat (30) @(posedge clk);
    for (int k = 0; k < 3; k++) begin
      if (k == 1) tick <= 1'b0;
      else wr(CTRL0_OFS, k == 0 ? 8'h88 : 8'h00);
      rdr(CNT_LO_OFS, rd);
      repeat (20) @(posedge clk);
      rdr(CNT_LO_OFS, rd2);
      chk(rd2, rd);
      tick <= 1'b1;
      wr(CTRL0_OFS, 8'h08);
      rdr(CNT_LO_OFS, rd2);
      chk(32'(k == 2 ? rd2 < 12 : rd2 > rd && rd2 < rd + 16), 32'h1);
    end
    $display("test hold done");
    // Waveform duty; a new duty each pass so a stale run length cannot match
    wr(PER_LO_OFS, 8'h14);
    for (int j = 0; j < 3; j++) begin
      wr(CMPA_LO_OFS, 8'(4 + j));
      start(c1(MODE_PWM, PINF_HIGH, j != 1, j == 2, 1'b1));
      repeat (100) @(posedge clk);
      chk(32'(j == 0 ? high_len : low_len), 32'(4 + j));
      chk(32'({fa, fp}), 32'h3);
    end
    // Forced levels; the unbuilt pulse code must stay inactive
    for (int j = 0; j < 3; j++) begin
      start(c1(MODE_PWM, j == 2 ? PINF_TOG : 2'(j), 1'b1, 1'b0, 1'b0));
      repeat (50) @(posedge clk);
      chk(32'(level), 32'(j == 1));
    end
    $display("test waveform done");
    close_out();
  end
endmodule // periodic_timer_tb
